// ==== core/drcs_regs.vh ====
`ifndef DRCS_REGS_VH
`define DRCS_REGS_VH
// register offsets
`define DRCS_ADDR_W 4
`define DRCS_OFF_CTRL 4'h0
`define DRCS_OFF_FUNC 4'h1
`define DRCS_OFF_LINK 4'h2
`define DRCS_OFF_CMD 4'h3
`define DRCS_OFF_STAT 4'h4
// drive mode values
`define DRCS_MODE_KEYPAD 3'h0
`define DRCS_MODE_TERM1 3'h1
`define DRCS_MODE_TERM2 3'h2
`define DRCS_MODE_SERIAL 3'h3
// ctrl fields
`define DRCS_CTRL_MODE_LSB 0
`define DRCS_CTRL_DIR_BIT 3
`define DRCS_CTRL_INH_LSB 4
`define DRCS_CTRL_AUTO_BIT 6
`define DRCS_CTRL_RSTRT_BIT 7
`define DRCS_CTRL_BIPOL_BIT 8
`define DRCS_CTRL_RESET 16'h0001
// function code fields
`define DRCS_FUNC_ONE_LSB 0
`define DRCS_FUNC_TWO_LSB 8
`define DRCS_FUNC_RESET 16'h0100
`define DRCS_FN_FWD 5'h00
`define DRCS_FN_REV 5'h01
// link fields
`define DRCS_LINK_PROT_BIT 0
`define DRCS_LINK_STN_LSB 8
`define DRCS_LINK_SPD_LSB 4
`define DRCS_LINK_RESET 16'h0130
`define DRCS_STN_MIN 8'h01
`define DRCS_STN_MAX 8'hfa
// serial command bits
`define DRCS_CMD_RUN_BIT 0
`define DRCS_CMD_REV_BIT 1
// direction inhibit
`define DRCS_INH_NONE 2'h0
`define DRCS_INH_FWD 2'h1
`define DRCS_INH_REV 2'h2
// power-on settle count, in clocks after reset
`define DRCS_SETTLE_CNT 2'h3
`endif

// ==== core/drcs_sync.v ====
`default_nettype none
module drcs_sync #(
	parameter W = 1
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);
reg [W-1:0] meta_reg;
reg [W-1:0] sync_reg;
always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		meta_reg <= {W{1'b0}};
		sync_reg <= {W{1'b0}};
	end else begin
		meta_reg <= async_i;
		sync_reg <= meta_reg;
	end
end
assign sync_o = sync_reg;
endmodule // drcs_sync
`default_nettype wire

// ==== core/drcs_top.v ====
// Summary of operation
// - keypad run starts with frequency, stop decelerates
// - keypad direction setting picks forward or reverse
// - remote keypad attached masks built-in keypad
// - function codes 0/1 map forward/reverse inputs
// - scheme one: forward input forward, reverse reverse
// - scheme one: both or neither input stops
// - scheme two: input one runs, two selects direction
// - serial mode takes run commands from link
// - bipolar source sets direction by polarity when enabled
// - negative bipolar input inverts commanded direction
// - polarity flip while running: stop then reverse
// - inhibit 0 none, 1 blocks forward, 2 reverse
// - autostart at power-up in terminal schemes only
// - restart after fault clear with run terminal
// - restart setting ignored in keypad/serial modes
`include "drcs_regs.vh"
`default_nettype none
module drcs_top (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [3:0] reg_addr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [15:0] reg_rdata_o,
	input wire key_run_i,
	input wire key_stop_i,
	input wire remote_key_run_i,
	input wire remote_key_stop_i,
	input wire remote_attached_i,
	input wire multi_input_one_i,
	input wire multi_input_two_i,
	input wire bipolar_negative_i,
	input wire freq_set_i,
	input wire fault_active_i,
	input wire motor_stopped_i,
	output reg run_o,
	output reg reverse_o
);
reg [15:0] ctrl_reg;
reg [15:0] func_reg;
reg [15:0] link_reg;
reg [1:0] cmd_reg;
reg key_latch_reg;
reg [1:0] wait_reg;
reg fault_d_reg;
reg armed_reg;
reg autostart_reg;
reg run_next;
reg rev_next;
// next values, one per flip-flop except fault_d_reg
reg [15:0] ctrl_next;
reg [15:0] func_next;
reg [15:0] link_next;
reg [1:0] cmd_next;
reg [15:0] rdata_next;
reg key_latch_next;
reg [1:0] wait_next;
reg autostart_next;
reg armed_next;
wire [6:0] pins_s;
wire key_run_s;
wire key_stop_s;
wire rkey_run_s;
wire rkey_stop_s;
wire rem_s;
wire in_one_s;
wire in_two_s;
wire neg_s;
wire [2:0] mode;
wire [1:0] inhibit;
wire [4:0] fn_one;
wire [4:0] fn_two;
wire term_mode;
wire fwd_in;
wire rev_in;
wire run_key;
wire stop_key;
wire [7:0] station;
// settle and arming helpers
wire settled;
wire fault_clear;
wire auto_arm;
reg want_run;
reg want_rev;
reg cmd_rev;
reg gated_run;
// terminals come from outside; keypad too, all synchronised
drcs_sync #(
	.W(7)
) u_sync (
	.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i),
	.async_i({key_run_i, key_stop_i, remote_key_run_i,
		remote_key_stop_i, remote_attached_i, multi_input_one_i,
		multi_input_two_i}),
	.sync_o(pins_s)
);
assign key_run_s = pins_s[6];
assign key_stop_s = pins_s[5];
assign rkey_run_s = pins_s[4];
assign rkey_stop_s = pins_s[3];
assign rem_s = pins_s[2];
assign in_one_s = pins_s[1];
assign in_two_s = pins_s[0];
drcs_sync #(
	.W(1)
) u_sync_pol (
	.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i),
	.async_i(bipolar_negative_i),
	.sync_o(neg_s)
);
assign mode = ctrl_reg[`DRCS_CTRL_MODE_LSB +: 3];
assign inhibit = ctrl_reg[`DRCS_CTRL_INH_LSB +: 2];
assign fn_one = func_reg[`DRCS_FUNC_ONE_LSB +: 5];
assign fn_two = func_reg[`DRCS_FUNC_TWO_LSB +: 5];
assign station = link_reg[`DRCS_LINK_STN_LSB +: 8];
assign term_mode = (mode == `DRCS_MODE_TERM1) ||
	(mode == `DRCS_MODE_TERM2);
// a terminal acts as run input only when its code selects it
function map_in;
	input [4:0] code;
	input [4:0] want;
	input pin;
	begin
		map_in = (code == want) & pin;
	end
endfunction
// inhibit setting against the wanted direction
function dir_blocked;
	input [1:0] inh;
	input rev;
	begin
		dir_blocked = ((inh == `DRCS_INH_FWD) && !rev) ||
			((inh == `DRCS_INH_REV) && rev);
	end
endfunction
// a station outside the legal range blocks serial run commands
function station_ok;
	input [7:0] stn;
	begin
		station_ok = (stn >= `DRCS_STN_MIN) && (stn <= `DRCS_STN_MAX);
	end
endfunction
assign fwd_in = map_in(fn_one, `DRCS_FN_FWD, in_one_s) |
	map_in(fn_two, `DRCS_FN_FWD, in_two_s);
assign rev_in = map_in(fn_one, `DRCS_FN_REV, in_one_s) |
	map_in(fn_two, `DRCS_FN_REV, in_two_s);
assign run_key = rem_s ? rkey_run_s : key_run_s;
assign stop_key = rem_s ? rkey_stop_s : key_stop_s;
// raw command per source, before inhibit and polarity
always @* begin
	want_run = 1'b0;
	cmd_rev = 1'b0;
	case (mode)
	`DRCS_MODE_KEYPAD: begin
		want_run = key_latch_reg;
		cmd_rev = ctrl_reg[`DRCS_CTRL_DIR_BIT];
	end
	`DRCS_MODE_TERM1: begin
		want_run = fwd_in ^ rev_in;
		cmd_rev = rev_in;
	end
	`DRCS_MODE_TERM2: begin
		want_run = fwd_in;
		cmd_rev = rev_in;
	end
	`DRCS_MODE_SERIAL: begin
		want_run = cmd_reg[`DRCS_CMD_RUN_BIT] &
			station_ok(station);
		cmd_rev = cmd_reg[`DRCS_CMD_REV_BIT];
	end
	default: begin
		want_run = 1'b0;
		cmd_rev = 1'b0;
	end
	endcase
	want_rev = cmd_rev;
	if (ctrl_reg[`DRCS_CTRL_BIPOL_BIT])
		want_rev = cmd_rev ^ neg_s;
	gated_run = want_run;
	if (dir_blocked(inhibit, want_rev))
		gated_run = 1'b0;
	// terminal level alone never starts: needs arming
	if (term_mode && !armed_reg)
		gated_run = 1'b0;
	if (fault_active_i)
		gated_run = 1'b0;
end
// reversal waits for the motor to stop first
always @* begin
	run_next = gated_run;
	rev_next = reverse_o;
	if (gated_run) begin
		if (run_o && (want_rev != reverse_o)) begin
			run_next = 1'b0;
		end else if (!run_o && !motor_stopped_i &&
			(want_rev != reverse_o)) begin
			run_next = 1'b0;
		end else begin
			rev_next = want_rev;
		end
	end
end
// bus writes; unmapped offsets and reserved bits change nothing
always @* begin
	ctrl_next = ctrl_reg;
	func_next = func_reg;
	link_next = link_reg;
	cmd_next = cmd_reg;
	if (reg_wr_i) begin
		case (reg_addr_i)
		`DRCS_OFF_CTRL: begin
			ctrl_next = {7'h00, reg_wdata_i[8:0]};
		end
		`DRCS_OFF_FUNC: begin
			func_next = {3'h0, reg_wdata_i[12:8], 3'h0,
				reg_wdata_i[4:0]};
		end
		// link settings are stored; only the station number is used here, to gate serial runs; the protocol lives outside
		`DRCS_OFF_LINK: begin
			link_next = {reg_wdata_i[15:8], 1'b0,
				reg_wdata_i[6:4], 3'h0, reg_wdata_i[0]};
		end
		`DRCS_OFF_CMD: begin
			cmd_next = reg_wdata_i[1:0];
		end
		default: begin
			cmd_next = cmd_reg;
		end
		endcase
	end
end
// read data stands one clock only and reads zero otherwise
always @* begin
	rdata_next = 16'h0000;
	if (reg_rd_i) begin
		case (reg_addr_i)
		`DRCS_OFF_CTRL: begin
			rdata_next = ctrl_reg;
		end
		`DRCS_OFF_FUNC: begin
			rdata_next = func_reg;
		end
		`DRCS_OFF_LINK: begin
			rdata_next = link_reg;
		end
		`DRCS_OFF_CMD: begin
			rdata_next = {14'h0000, cmd_reg};
		end
		// status shows the decision as the drive sees it
		`DRCS_OFF_STAT: begin
			rdata_next = {10'h000, armed_reg, key_latch_reg, fwd_in,
				rev_in, reverse_o, run_o};
		end
		default: begin
			rdata_next = 16'h0000;
		end
		endcase
	end
end
// settings survive until reset; writes land one clock after the strobe
always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		ctrl_reg <= `DRCS_CTRL_RESET;
		func_reg <= `DRCS_FUNC_RESET;
		link_reg <= `DRCS_LINK_RESET;
		cmd_reg <= 2'h0;
		reg_rdata_o <= 16'h0000;
	end else begin
		ctrl_reg <= ctrl_next;
		func_reg <= func_next;
		link_reg <= link_next;
		cmd_reg <= cmd_next;
		reg_rdata_o <= rdata_next;
	end
end
// keypad run latch; stop and fault both win over the run key
always @* begin
	key_latch_next = key_latch_reg;
	if (mode != `DRCS_MODE_KEYPAD || stop_key || fault_active_i) begin
		key_latch_next = 1'b0;
	end else if (run_key && freq_set_i) begin
		key_latch_next = 1'b1;
	end
end
// settle count covers the two synchroniser stages
assign settled = (wait_reg == `DRCS_SETTLE_CNT);
assign fault_clear = fault_d_reg && !fault_active_i;
// power-on start is sampled once, so a later mode write cannot start
assign auto_arm = settled && autostart_reg && term_mode &&
	ctrl_reg[`DRCS_CTRL_AUTO_BIT];
always @* begin
	wait_next = wait_reg;
	autostart_next = autostart_reg;
	if (!settled) begin
		wait_next = wait_reg + 2'h1;
	end else begin
		autostart_next = 1'b0;
	end
end
// arming: run input seen off, power-on start, or fault clear
always @* begin
	armed_next = armed_reg;
	if (auto_arm) begin
		armed_next = 1'b1;
	end
	if (!term_mode) begin
		armed_next = 1'b0;
	end else if (!want_run && settled) begin
		// before settling the pins still read reset zeros
		armed_next = 1'b1;
	end else if (fault_clear && ctrl_reg[`DRCS_CTRL_RSTRT_BIT]) begin
		armed_next = 1'b1;
	end else if (fault_active_i) begin
		armed_next = 1'b0;
	end
end
// run and direction leave from flip-flops so the drive sees no glitch
always @(posedge sys_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		key_latch_reg <= 1'b0;
		wait_reg <= 2'h0;
		fault_d_reg <= 1'b0;
		armed_reg <= 1'b0;
		autostart_reg <= 1'b1;
		run_o <= 1'b0;
		reverse_o <= 1'b0;
	end else begin
		key_latch_reg <= key_latch_next;
		wait_reg <= wait_next;
		fault_d_reg <= fault_active_i;
		armed_reg <= armed_next;
		autostart_reg <= autostart_next;
		run_o <= run_next;
		reverse_o <= rev_next;
	end
end
endmodule // drcs_top
`default_nettype wire

// ==== sim/drcs_chk.sv ====
`default_nettype none
module drcs_chk (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic key_stop_i,
	input wire logic remote_attached_i,
	input wire logic multi_input_one_i,
	input wire logic multi_input_two_i,
	input wire logic fault_active_i,
	input wire logic run_o,
	input wire logic reverse_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [8:0] ctl_reg;
	// shadow of the control word, snooped from bus writes
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			ctl_reg <= 9'h001;
		else if (reg_wr_i && reg_addr_i == 4'h0)
			ctl_reg <= reg_wdata_i[8:0];
	wire kp = ctl_reg[2:0] == 3'h0;
	wire t1 = ctl_reg[2:0] == 3'h1 && !ctl_reg[8];
	wire t2 = ctl_reg[2:0] == 3'h2 && !ctl_reg[8];
	// windows cover the two-stage pin synchroniser plus output register
	sequence s_both;
		(t1 && multi_input_one_i && multi_input_two_i)[*5];
	endsequence
	sequence s_idle;
		((t1 || t2) && !multi_input_one_i && (t2 || !multi_input_two_i))[*5];
	endsequence
	sequence s_two;
		(t2 && $stable(multi_input_two_i))[*6];
	endsequence
	AST_KEY_STOP: assert property (
		(kp && !remote_attached_i && key_stop_i)[*5] |-> !run_o)
		else $error("stop key did not stop");
	AST_BOTH_STOP: assert property (s_both |-> !run_o)
		else $error("both inputs on but running");
	AST_IDLE_STOP: assert property (s_idle |-> !run_o)
		else $error("running without run input");
	AST_TWO_DIR: assert property (
		s_two ##0 run_o |-> reverse_o == multi_input_two_i)
		else $error("direction does not follow input two");
	AST_INH_FWD: assert property (
		(ctl_reg[5:4] == 2'h1)[*3] |-> !(run_o && !reverse_o))
		else $error("forward run while blocked");
	AST_INH_REV: assert property (
		(ctl_reg[5:4] == 2'h2)[*3] |-> !(run_o && reverse_o))
		else $error("reverse run while blocked");
	AST_DIR_FLIP: assert property ($changed(reverse_o) |-> !$past(run_o))
		else $error("direction flipped while running");
	AST_FAULT: assert property (fault_active_i |=> !run_o)
		else $error("running during fault");
endmodule // drcs_chk
`default_nettype wire

// ==== sim/drcs_motor.sv ====
`default_nettype none
module drcs_motor (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	output logic stopped_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int spd_reg;
	// coasts for a while so reversal must really wait for standstill
	always @(posedge sys_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			spd_reg <= 0;
		else if (run_i)
			spd_reg <= 6;
		else if (spd_reg > 0)
			spd_reg <= spd_reg - 1;
	assign stopped_o = spd_reg == 0;
endmodule // drcs_motor
`default_nettype wire

// ==== sim/drcs_bench.sv ====
`default_nettype none
module drcs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 1'h0, rst_n_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0, reg_rdata_o;
	logic key_run_i = 1'h0, key_stop_i = 1'h0, remote_key_run_i = 1'h0;
	logic remote_key_stop_i = 1'h0, remote_attached_i = 1'h0;
	logic multi_input_one_i = 1'h0, multi_input_two_i = 1'h0;
	logic bipolar_negative_i = 1'h0, fault_active_i = 1'h0, freq_set_i = 1'h1;
	logic motor_stopped_i, run_o, reverse_o;
	int miscompares = 0, compares = 0, cyc = 0, a = 0, b = 0;
	drcs_top i_drcs_top (.sys_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .key_run_i, .key_stop_i,
		.remote_key_run_i, .remote_key_stop_i, .remote_attached_i,
		.multi_input_one_i, .multi_input_two_i, .bipolar_negative_i,
		.freq_set_i, .fault_active_i, .motor_stopped_i, .run_o, .reverse_o);
	drcs_motor i_drcs_motor (.sys_clk_i, .rst_n_i, .run_i(run_o),
		.stopped_o(motor_stopped_i));
	initial forever #20 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 8000) begin
			miscompares++;
			print_verdict;
		end
	end
	task automatic chk(input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] ad, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= ad;
		reg_wdata_i <= d;
		reg_wr_i <= 1'h1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] ad, input logic [15:0] e);
		@(posedge sys_clk_i);
		reg_addr_i <= ad;
		reg_rd_i <= 1'h1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'h0;
		#1 chk(reg_rdata_o, e);
	endtask
	task automatic pins(input int x, y);
		@(posedge sys_clk_i);
		multi_input_one_i <= x[0];
		multi_input_two_i <= y[0];
		a = x % 2;
		b = y % 2;
	endtask
	// steady-state model: settle long enough for a full reversal
	task automatic step(input int m, inh, bip);
		int run, rev;
		repeat (40) @(posedge sys_clk_i);
		rev = b ^ (bip & bipolar_negative_i);
		run = m == 1 ? a ^ b : a;
		if (inh == 1 + rev)
			run = 0;
		chk(16'(run_o), 16'(run));
		if (run)
			chk(16'(reverse_o), 16'(rev));
	endtask
	task automatic hit(input logic [3:0] k, input int e);
		@(posedge sys_clk_i);
		{key_run_i, key_stop_i, remote_key_run_i, remote_key_stop_i} <= k;
		repeat (5) @(posedge sys_clk_i);
		{key_run_i, key_stop_i, remote_key_run_i, remote_key_stop_i} <= 4'h0;
		repeat (30) @(posedge sys_clk_i);
		chk(16'(run_o), 16'(e));
	endtask
	task automatic print_verdict;
		$display("%0d compares, %0d miscompares", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h3cf5fb57));
		repeat (4) @(posedge sys_clk_i);
		rst_n_i <= 1'h1;
		rd(4'h0, 16'h0001);
		rd(4'h1, 16'h0100);
		rd(4'h2, 16'h0130);
		rd(4'h9, 16'h0000);
		for (int i = 0; i < 10; i++) begin
			pins($urandom % 2, $urandom % 2);
			step(1, 0, 0);
		end
		pins(1, 1);
		step(1, 0, 0);
		$display("scheme one done");
		pins(0, 0);
		wr(4'h0, 16'h0002);
		for (int i = 0; i < 5; i++) begin
			pins(i % 2, i / 2 % 2);
			step(2, 0, 0);
		end
		for (int n = 1; n < 3; n++) begin
			pins(0, 0);
			wr(4'h0, 16'(1 + n * 16));
			for (int i = 0; i < 3; i++) begin
				pins(i % 2, i / 2);
				step(1, n, 0);
			end
		end
		pins(0, 0);
		wr(4'h0, 16'h0101);
		for (int i = 0; i < 4; i++) begin
			bipolar_negative_i <= (i == 1 || i == 2);
			pins(i < 2, i >= 2);
			step(1, 0, 1);
		end
		$display("direction tests done");
		pins(0, 0);
		wr(4'h0, 16'h0081);
		pins(1, 0);
		step(1, 0, 0);
		fault_active_i <= 1'h1;
		step(1, 1, 0);
		fault_active_i <= 1'h0;
		step(1, 0, 0);
		wr(4'h0, 16'h0001);
		fault_active_i <= 1'h1;
		pins(1, 0);
		fault_active_i <= 1'h0;
		repeat (40) @(posedge sys_clk_i);
		chk(16'(run_o), 16'h0);
		pins(0, 0);
		wr(4'h0, 16'h0008);
		freq_set_i <= 1'h0;
		hit(4'h8, 0);
		freq_set_i <= 1'h1;
		hit(4'h8, 1);
		chk(16'(reverse_o), 16'h1);
		rd(4'h4, 16'h0013);
		hit(4'h4, 0);
		remote_attached_i <= 1'h1;
		hit(4'h8, 0);
		hit(4'h2, 1);
		hit(4'h1, 0);
		remote_attached_i <= 1'h0;
		wr(4'h0, 16'h0003);
		wr(4'h3, 16'h0003);
		rd(4'h3, 16'h0003);
		hit(4'h0, 1);
		chk(16'(reverse_o), 16'h1);
		wr(4'h3, 16'h0000);
		hit(4'h0, 0);
		wr(4'h2, 16'h0030);
		wr(4'h3, 16'h0001);
		hit(4'h0, 0);
		$display("keypad and link done");
		rst_n_i <= 1'h0;
		pins(1, 0);
		rst_n_i <= 1'h1;
		wr(4'h0, 16'h0041);
		hit(4'h0, 1);
		// no autostart: a run terminal held over reset must not start
		rst_n_i <= 1'h0;
		@(posedge sys_clk_i);
		rst_n_i <= 1'h1;
		repeat (40) @(posedge sys_clk_i);
		chk(16'(run_o), 16'h0);
		pins(0, 0);
		pins(1, 0);
		step(1, 0, 0);
		$display("power-on tests done");
		print_verdict;
	end
endmodule // drcs_bench
bind drcs_top drcs_chk i_drcs_chk (.sys_clk_i, .rst_n_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .key_stop_i, .remote_attached_i,
	.multi_input_one_i, .multi_input_two_i, .fault_active_i, .run_o,
	.reverse_o);
`default_nettype wire
